// file: hw/prm_consts.svh
`ifndef PRM_CONSTS_SVH
`define PRM_CONSTS_SVH
// register indices on the plain port
`define PRM_ADDR_REMAP 4'h0
`define PRM_ADDR_PA_DATA 4'h1
`define PRM_ADDR_PA_DIR 4'h2
`define PRM_ADDR_PA_WAKE 4'h3
`define PRM_ADDR_PB_DATA 4'h4
`define PRM_ADDR_PB_DIR 4'h5
`define PRM_ADDR_PC_DATA 4'h6
`define PRM_ADDR_PC_DIR 4'h7
`define PRM_ADDR_CTRL 4'h8
// remap register fields
`define PRM_BIT_IRQ1_SEL 7
`define PRM_BIT_IRQ0_SEL 6
`define PRM_BIT_TIMER1_EXT_CLOCK_SEL 5
`define PRM_BIT_TIMER0_EXT_CLOCK_SEL 4
`define PRM_REMAP_MASK 8'hf0
// reset values
`define PRM_RST_REMAP 8'h00
`define PRM_RST_PORT 8'hff
`define PRM_RST_WAKE 8'h00
// control register fields
`define PRM_BIT_LOWPOWER 0
`define PRM_BIT_WAKE_FLAG 1
`endif

// file: hw/prm_pin_remap.sv
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
`include "prm_consts.svh"
module prm_pin_remap
  import prm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pins
  input wire logic [7:0] pa_in,
  input wire logic [7:0] pb_in,
  input wire logic [7:0] pc_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  output logic [7:0] pc_out,
  output logic [7:0] pc_oe,
  // routed functions
  output logic ext_irq1_input,
  output logic ext_irq0_input,
  output logic timer1_ext_clock,
  output logic timer0_ext_clock,
  // power
  output logic wake_up
);
  prm_byte_t pin_remap_register_reg;
  prm_byte_t port_a_data_reg, port_a_direction_reg, port_a_wake_enable_reg;
  prm_byte_t pb_data_reg, pb_dir_reg, pc_data_reg, pc_dir_reg;
  prm_byte_t pa_sync, pb_sync, pc_sync, pa_prev_reg;
  prm_pwr_t pwr_reg;
  logic wake_flag_reg;
  logic ext_irq1_pin_select, ext_irq0_pin_select, timer1_clk_pin_select, timer0_clk_pin_select;
  prm_byte_t pa_fall;
  logic wake_event;
  prm_byte_t pa_view, pb_view, pc_view;

  prm_sync sync_a (.clock(clock), .rst_b(rst_b), .d(pa_in), .q(pa_sync));
  prm_sync sync_b (.clock(clock), .rst_b(rst_b), .d(pb_in), .q(pb_sync));
  prm_sync sync_c (.clock(clock), .rst_b(rst_b), .d(pc_in), .q(pc_sync));

  // output pins read the latch, inputs read the pin
  function automatic prm_byte_t port_view(input prm_byte_t data, input prm_byte_t dir, input prm_byte_t pins);
    port_view = (data & ~dir) | (pins & dir);
  endfunction

  function automatic logic hit(input logic [3:0] addr);
    hit = reg_wr && (reg_addr == addr);
  endfunction

  assign ext_irq1_pin_select = pin_remap_register_reg[`PRM_BIT_IRQ1_SEL];
  assign ext_irq0_pin_select = pin_remap_register_reg[`PRM_BIT_IRQ0_SEL];
  assign timer1_clk_pin_select = pin_remap_register_reg[`PRM_BIT_TIMER1_EXT_CLOCK_SEL];
  assign timer0_clk_pin_select = pin_remap_register_reg[`PRM_BIT_TIMER0_EXT_CLOCK_SEL];

  // a function result cannot be bit-selected, so each port view is a named net
  assign pa_view = port_view(port_a_data_reg, port_a_direction_reg, pa_sync);
  assign pb_view = port_view(pb_data_reg, pb_dir_reg, pb_sync);
  assign pc_view = port_view(pc_data_reg, pc_dir_reg, pc_sync);

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      pin_remap_register_reg <= `PRM_RST_REMAP;
    else if (hit(`PRM_ADDR_REMAP))
      pin_remap_register_reg <= reg_wdata & `PRM_REMAP_MASK;
  end

  // all ones at reset so every pin starts as input and latches hold high
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      port_a_data_reg <= `PRM_RST_PORT;
      port_a_direction_reg <= `PRM_RST_PORT;
      pb_data_reg <= `PRM_RST_PORT;
      pb_dir_reg <= `PRM_RST_PORT;
      pc_data_reg <= `PRM_RST_PORT;
      pc_dir_reg <= `PRM_RST_PORT;
    end
    else
    begin
      // whole-byte writes only: software does bit updates by read-modify-write
      if (hit(`PRM_ADDR_PA_DATA))
        port_a_data_reg <= reg_wdata;
      if (hit(`PRM_ADDR_PA_DIR))
        port_a_direction_reg <= reg_wdata;
      if (hit(`PRM_ADDR_PB_DATA))
        pb_data_reg <= reg_wdata;
      if (hit(`PRM_ADDR_PB_DIR))
        pb_dir_reg <= reg_wdata;
      if (hit(`PRM_ADDR_PC_DATA))
        pc_data_reg <= reg_wdata;
      if (hit(`PRM_ADDR_PC_DIR))
        pc_dir_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      port_a_wake_enable_reg <= `PRM_RST_WAKE;
    else if (hit(`PRM_ADDR_PA_WAKE))
      port_a_wake_enable_reg <= reg_wdata;
  end

  // pins always drive the latch where direction is 0, whatever function routes them
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      pa_out <= `PRM_RST_PORT;
      pa_oe <= 8'h00;
      pb_out <= `PRM_RST_PORT;
      pb_oe <= 8'h00;
      pc_out <= `PRM_RST_PORT;
      pc_oe <= 8'h00;
    end
    else
    begin
      pa_out <= port_a_data_reg;
      pa_oe <= ~port_a_direction_reg;
      pb_out <= pb_data_reg;
      pb_oe <= ~pb_dir_reg;
      pc_out <= pc_data_reg;
      pc_oe <= ~pc_dir_reg;
    end
  end

  // inputs take the pin level, or the latch when the pin is an output;
  // priority is fixed: the remap select alone picks the source pin
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      ext_irq1_input <= 1'b1;
      ext_irq0_input <= 1'b1;
      timer1_ext_clock <= 1'b1;
      timer0_ext_clock <= 1'b1;
    end
    else
    begin
      ext_irq1_input <= ext_irq1_pin_select ? pc_view[1] : pb_view[0];
      ext_irq0_input <= ext_irq0_pin_select ? pc_view[0] : pa_view[2];
      timer0_ext_clock <= timer0_clk_pin_select ? pc_view[2] : pa_view[6];
      timer1_ext_clock <= timer1_clk_pin_select ? pc_view[3] : pb_view[0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      pa_prev_reg <= 8'hff;
    else
      pa_prev_reg <= pa_sync;
  end

  assign pa_fall = pa_prev_reg & ~pa_sync & port_a_wake_enable_reg;
  assign wake_event = (pwr_reg == PRM_SLEEP) && (pa_fall != 8'h00);

  // sleep entered by writing the low-power bit; a falling edge on a wake-enabled port A pin ends it
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      pwr_reg <= PRM_RUN;
    else
      case (pwr_reg)
        PRM_RUN:
          if (hit(`PRM_ADDR_CTRL) && reg_wdata[`PRM_BIT_LOWPOWER])
            pwr_reg <= PRM_SLEEP;
        PRM_SLEEP:
          if (wake_event)
            pwr_reg <= PRM_RUN;
        default:
          pwr_reg <= PRM_RUN;
      endcase
  end

  // sticky wake flag; a new wake beats a clear in the same cycle
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      wake_flag_reg <= 1'b0;
    else if (wake_event)
      wake_flag_reg <= 1'b1;
    else if (hit(`PRM_ADDR_CTRL) && reg_wdata[`PRM_BIT_WAKE_FLAG])
      wake_flag_reg <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      wake_up <= 1'b0;
    else
      wake_up <= wake_event;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      case (reg_addr)
        `PRM_ADDR_REMAP: reg_rdata <= pin_remap_register_reg;
        `PRM_ADDR_PA_DATA: reg_rdata <= port_view(port_a_data_reg, port_a_direction_reg, pa_sync);
        `PRM_ADDR_PA_DIR: reg_rdata <= port_a_direction_reg;
        `PRM_ADDR_PA_WAKE: reg_rdata <= port_a_wake_enable_reg;
        `PRM_ADDR_PB_DATA: reg_rdata <= port_view(pb_data_reg, pb_dir_reg, pb_sync);
        `PRM_ADDR_PB_DIR: reg_rdata <= pb_dir_reg;
        `PRM_ADDR_PC_DATA: reg_rdata <= port_view(pc_data_reg, pc_dir_reg, pc_sync);
        `PRM_ADDR_PC_DIR: reg_rdata <= pc_dir_reg;
        `PRM_ADDR_CTRL: reg_rdata <= {6'h00, wake_flag_reg, pwr_reg == PRM_SLEEP};
        default: reg_rdata <= 8'h00;
      endcase
    else
      reg_rdata <= 8'h00;
  end

  chk_reset_ports: assert property (@(posedge clock) !rst_b |=> pa_out == 8'hff && pa_oe == 8'h00)
    else $error("port not high input after reset");
  chk_irq1_route: assert property (@(posedge clock) disable iff (!rst_b)
    ext_irq1_pin_select && pc_dir_reg[1] |=> ext_irq1_input == $past(pc_sync[1]))
    else $error("irq1 not from c1");
  chk_irq0_route: assert property (@(posedge clock) disable iff (!rst_b)
    !ext_irq0_pin_select && port_a_direction_reg[2] |=> ext_irq0_input == $past(pa_sync[2]))
    else $error("irq0 not from a2");
  chk_timer0_ext_clock_route: assert property (@(posedge clock) disable iff (!rst_b)
    timer0_clk_pin_select && pc_dir_reg[2] |=> timer0_ext_clock == $past(pc_sync[2]))
    else $error("timer0 clock not from c2");
  chk_wake_edge: assert property (@(posedge clock) disable iff (!rst_b)
    pwr_reg == PRM_SLEEP && (pa_fall != 8'h00) |=> wake_up && pwr_reg == PRM_RUN)
    else $error("missed wake");
  chk_no_wake_run: assert property (@(posedge clock) disable iff (!rst_b)
    pwr_reg == PRM_RUN |=> !wake_up)
    else $error("wake while running");
  chk_wake_masked: assert property (@(posedge clock) disable iff (!rst_b)
    port_a_wake_enable_reg == 8'h00 |=> !wake_up)
    else $error("wake from disabled pin");
  chk_out_latch: assert property (@(posedge clock) disable iff (!rst_b)
    !pb_dir_reg[0] |=> pb_oe[0] && pb_out[0] == $past(pb_data_reg[0]))
    else $error("output not from latch");
endmodule

// file: hw/prm_pkg.sv
package prm_pkg;
  typedef logic [7:0] prm_byte_t;
  typedef enum logic [1:0] {PRM_RUN, PRM_SLEEP} prm_pwr_t;
endpackage

// file: hw/prm_sync.sv
`timescale 1ns/1ns
// two-flop synchroniser for a bank of pins
module prm_sync
  import prm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // data
  input wire prm_byte_t d,
  output prm_byte_t q
);
  prm_byte_t meta_reg;
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      meta_reg <= 8'hff;
      q <= 8'hff;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// file: verification/prm_ext_pins.sv
`timescale 1ns/1ns
module prm_ext_pins
  import prm_pkg::*;
(
  // outside levels
  input wire prm_byte_t ext_a,
  input wire prm_byte_t ext_b,
  input wire prm_byte_t ext_c,
  // device drivers
  input wire prm_byte_t pa_out,
  input wire prm_byte_t pa_oe,
  input wire prm_byte_t pb_out,
  input wire prm_byte_t pb_oe,
  input wire prm_byte_t pc_out,
  input wire prm_byte_t pc_oe,
  // resolved pins
  output prm_byte_t pa_in,
  output prm_byte_t pb_in,
  output prm_byte_t pc_in
);
  // outside is a weak source, so a driving device always wins
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_a);
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b);
  assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext_c);
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ns
`include "prm_consts.svh"
module testbench
  import prm_pkg::*;
;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  prm_byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  prm_byte_t ext_a = 8'h5a;
  prm_byte_t ext_b = 8'h00;
  prm_byte_t ext_c = 8'h00;
  prm_byte_t reg_rdata, pa_in, pb_in, pc_in, pa_out, pa_oe, pb_out, pb_oe, pc_out, pc_oe, v;
  logic ext_irq1_input, ext_irq0_input, timer1_ext_clock, timer0_ext_clock, wake_up;
  int err_count = 0;
  int compares = 0;

  prm_pin_remap prm_pin_remap_i (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pa_in, .pb_in, .pc_in, .pa_out, .pa_oe, .pb_out, .pb_oe, .pc_out, .pc_oe,
    .ext_irq1_input, .ext_irq0_input, .timer1_ext_clock, .timer0_ext_clock, .wake_up);
  prm_ext_pins prm_ext_pins_i (.ext_a, .ext_b, .ext_c, .pa_out, .pa_oe, .pb_out, .pb_oe,
    .pc_out, .pc_oe, .pa_in, .pb_in, .pc_in);

  always #50 clock = ~clock;

  task automatic chk(input prm_byte_t got, input prm_byte_t exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input prm_byte_t d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [3:0] a, input prm_byte_t exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // pins pass two sync flops and an output flop
  task automatic settle;
    repeat (4) @(posedge clock);
    #1;
  endtask

  task automatic count_wake(output prm_byte_t n);
    n = 8'h00;
    repeat (8)
    begin
      @(posedge clock);
      #1 if (wake_up === 1'b1) n++;
    end
  endtask

  function automatic prm_byte_t route_exp(prm_byte_t s, prm_byte_t a, prm_byte_t b, prm_byte_t c);
    return {4'h0, s[7] ? c[1] : b[0], s[6] ? c[0] : a[2], s[5] ? c[3] : b[0], s[4] ? c[2] : a[6]};
  endfunction

  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    #1 chk(pa_out, 8'hff);
    chk(pc_oe, 8'h00);
    rdchk(`PRM_ADDR_REMAP, 8'h00);
    rdchk(`PRM_ADDR_PA_DIR, 8'hff);
    rdchk(`PRM_ADDR_PC_DIR, 8'hff);
    rdchk(`PRM_ADDR_PA_WAKE, 8'h00);
    rdchk(`PRM_ADDR_PA_DATA, 8'h5a);
    wr(4'h9, 8'hff);
    rdchk(4'h9, 8'h00);
    $display("test reset and map done");
    for (int i = 0; i < 32; i++)
    begin
      ext_a <= i[4] ? 8'h00 : 8'hff;
      ext_b <= i[4] ? 8'h00 : 8'hff;
      ext_c <= i[4] ? 8'hff : 8'h00;
      wr(`PRM_ADDR_REMAP, {i[3:0], 4'hf});
      settle;
      v = {4'h0, ext_irq1_input, ext_irq0_input, timer1_ext_clock, timer0_ext_clock};
      chk(v, route_exp({i[3:0], 4'h0}, ext_a, ext_b, ext_c));
    end
    rdchk(`PRM_ADDR_REMAP, 8'hf0);
    rdchk(`PRM_ADDR_PC_DATA, 8'hff);
    $display("test routing done");
    ext_a <= 8'h5a;
    wr(`PRM_ADDR_REMAP, 8'h00);
    wr(`PRM_ADDR_PA_DIR, 8'h0f);
    settle;
    chk(pa_oe, 8'hf0);
    chk(pa_out, 8'hff);
    rdchk(`PRM_ADDR_PA_DATA, 8'hfa);
    wr(`PRM_ADDR_PA_DATA, 8'hfa & 8'h7f);
    settle;
    chk(pa_out, 8'h7a);
    rdchk(`PRM_ADDR_PA_DATA, 8'h7a);
    wr(`PRM_ADDR_PB_DATA, 8'h0f);
    wr(`PRM_ADDR_PB_DIR, 8'hfe);
    settle;
    chk(pb_oe, 8'h01);
    chk(pb_out, 8'h0f);
    chk(pc_out, 8'hff);
    chk({6'h00, ext_irq1_input, timer1_ext_clock}, 8'h03);
    rdchk(`PRM_ADDR_PB_DATA, 8'h01);
    $display("test port data done");
    wr(`PRM_ADDR_PA_WAKE, 8'h08);
    rdchk(`PRM_ADDR_PA_WAKE, 8'h08);
    wr(`PRM_ADDR_CTRL, 8'h01);
    rdchk(`PRM_ADDR_CTRL, 8'h01);
    ext_a <= 8'h58;
    count_wake(v);
    chk(v, 8'h00);
    ext_a <= 8'h50;
    count_wake(v);
    chk(v, 8'h01);
    rdchk(`PRM_ADDR_CTRL, 8'h02);
    wr(`PRM_ADDR_CTRL, 8'h02);
    rdchk(`PRM_ADDR_CTRL, 8'h00);
    ext_a <= 8'h58;
    count_wake(v);
    chk(v, 8'h00);
    ext_a <= 8'h50;
    count_wake(v);
    chk(v, 8'h00);
    $display("test wake done");
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    #1 chk(pa_out, 8'hff);
    chk(pb_oe, 8'h00);
    chk(pb_out, 8'hff);
    rdchk(`PRM_ADDR_PA_DIR, 8'hff);
    rdchk(`PRM_ADDR_PB_DIR, 8'hff);
    rdchk(`PRM_ADDR_PA_WAKE, 8'h00);
    rdchk(`PRM_ADDR_REMAP, 8'h00);
    rdchk(`PRM_ADDR_CTRL, 8'h00);
    $display("test mid-run reset done");
    conclude;
  end

  initial
  begin
    #(3000 * 100);
    err_count++;
    conclude;
  end
endmodule
